// [design/iwd_watchdog.sv]
// iwd_watchdog: io-mapped watchdog timer with byte-wide port access
// assumes: io strobes are synchronous one-cycle pulses on core_clk
`timescale 1ns/1ps
// Summary of operation
// RQ1 - The registers are decoded as byte offsets from io base A00h.
// RQ2 - Writing 0Ch to offset 47h switches the watchdog function on.
// RQ3 - Bit 7 at offset 65h picks the unit, 0 for minutes by default, 1 for seconds.
// RQ4 - Offset 66h holds the 8-bit time-out count, 0 to 255, in the chosen unit.
// RQ5 - Writing zero to the time-out count disables the watchdog.
// RQ6 - Status bit 0 is read/write and reads 1 after a time-out, 0 while counting.
// RQ7 - When enabled with a nonzero count the timer counts down per unit and expires.
module iwd_watchdog #(
  parameter int SEC_CYCLES = iwd_pkg::SEC_CYCLES
) (
  input wire logic core_clk,        // 200 MHz clock
  input wire logic rst,             // async reset, high
  input wire logic [15:0] ioAddr,   // io port address
  input wire logic ioWr,            // write strobe, one cycle
  input wire logic ioRd,            // read strobe, one cycle
  input wire logic [7:0] ioWdata,   // write byte
  output logic [7:0] ioRdata,       // read byte, valid cycle after ioRd
  output logic timeoutOut           // high while time-out status set
);
  initial begin
    if (SEC_CYCLES < 1) $error("iwd_watchdog: SEC_CYCLES must be positive");
  end

  function automatic logic hit(input logic [15:0] a, input logic [7:0] ofs);
    hit = (a == iwd_pkg::IO_BASE + {8'h00, ofs}); // [RQ1]
  endfunction : hit

  iwd_tick_if tk ();

  // countQ is what software reads back, cntQ the live down-counter
  logic [7:0] enableQ;
  logic [7:0] enableD;
  logic [7:0] unitQ;
  logic [7:0] unitD;
  logic [7:0] countQ;
  logic [7:0] countD;
  logic [7:0] cntQ;
  logic [7:0] cntD;
  logic [7:0] rdQ;
  logic [7:0] rdD;
  logic statusQ;
  logic statusD;
  logic runQ;
  logic runD;
  logic wdOn;
  logic wrEn;
  logic wrUnit;
  logic wrCnt;
  logic wrSt;
  logic expire;
  logic stopReq;

  always_comb begin
    wrEn = ioWr && hit(ioAddr, iwd_pkg::OFS_ENABLE);
    wrUnit = ioWr && hit(ioAddr, iwd_pkg::OFS_UNIT);
    wrCnt = ioWr && hit(ioAddr, iwd_pkg::OFS_COUNT);
    wrSt = ioWr && hit(ioAddr, iwd_pkg::OFS_STATUS);
    wdOn = (enableQ == iwd_pkg::ENABLE_KEY); // [RQ2]
    stopReq = !wdOn || cntQ == 8'h00 || statusQ; // [RQ5]
    // a reload in the same cycle as the last tick wins: it is a kick
    expire = runQ && tk.tick && (cntQ == 8'h01) && !wrCnt && !stopReq; // [RQ7]
    enableD = wrEn ? ioWdata : enableQ; // [RQ2]
    unitD = wrUnit ? {ioWdata[iwd_pkg::UNIT_SEC_BIT], 7'h00} : unitQ; // [RQ3]
    countD = wrCnt ? ioWdata : countQ; // [RQ4]
    cntD = cntQ;
    runD = runQ;
    if (wrCnt) begin
      // reload restarts the unit divider; zero stops the timer
      cntD = ioWdata; // [RQ4]
      runD = 1'b0; // [RQ5]
    end else if (stopReq) begin
      runD = 1'b0; // [RQ5]
    end else if (!runQ) begin
      runD = 1'b1; // [RQ7]
    end else if (tk.tick) begin
      cntD = cntQ - 8'h01; // [RQ7]
      if (expire) begin
        runD = 1'b0;
      end
    end
    // expiry wins over a software write in the same cycle
    statusD = statusQ;
    if (wrSt) begin
      statusD = ioWdata[iwd_pkg::STATUS_BIT]; // [RQ6]
    end
    if (expire) begin
      statusD = 1'b1; // [RQ6] [RQ7]
    end
    rdD = rdQ;
    if (ioRd) begin
      rdD = iwd_pkg::READ_IDLE;
      if (hit(ioAddr, iwd_pkg::OFS_ENABLE)) begin
        rdD = enableQ;
      end else if (hit(ioAddr, iwd_pkg::OFS_UNIT)) begin
        rdD = unitQ;
      end else if (hit(ioAddr, iwd_pkg::OFS_COUNT)) begin
        rdD = countQ;
      end else if (hit(ioAddr, iwd_pkg::OFS_STATUS)) begin
        rdD = {7'h00, statusQ}; // [RQ6]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableQ <= iwd_pkg::ENABLE_RST;
      unitQ <= iwd_pkg::UNIT_RST;
      countQ <= iwd_pkg::COUNT_RST;
      cntQ <= iwd_pkg::COUNT_RST;
      runQ <= 1'b0;
      statusQ <= 1'b0;
      rdQ <= iwd_pkg::READ_IDLE;
    end else begin
      enableQ <= enableD;
      unitQ <= unitD;
      countQ <= countD;
      cntQ <= cntD;
      runQ <= runD;
      statusQ <= statusD;
      rdQ <= rdD;
    end
  end

  assign tk.run = runQ;
  assign tk.unitSec = unitQ[iwd_pkg::UNIT_SEC_BIT];
  assign ioRdata = rdQ;
  assign timeoutOut = statusQ;

  iwd_prescaler #(.SEC_CYCLES(SEC_CYCLES), .MIN_SECS(iwd_pkg::MINUTE_SECONDS)) uScaler (
    .core_clk(core_clk),
    .rst(rst),
    .tk(tk)
  );

  sequence wrCountNz;
    wrCnt && ioWdata != 8'h00;
  endsequence
  sequence liveTick;
    runQ && tk.tick && !wrCnt && !stopReq;
  endsequence
  sequence lastTick;
    liveTick ##0 cntQ == 8'h01;
  endsequence
  sequence keyMiss;
    wrEn && ioWdata != iwd_pkg::ENABLE_KEY;
  endsequence
  sequence offBase;
    ioAddr[15:8] != iwd_pkg::IO_BASE[15:8];
  endsequence

  decode_read_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    ioRd && ioAddr == 16'h0A66 |=> ioRdata == $past(countQ))
    else $error("count register not read back at base plus 66h");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    ioRd ##0 offBase |=> ioRdata == iwd_pkg::READ_IDLE)
    else $error("read off the io base did not return the idle byte");
  unmapped_write_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    ioWr ##0 offBase |=> enableQ == $past(enableQ) && unitQ == $past(unitQ)
      && countQ == $past(countQ))
    else $error("write off the io base changed a register");
  read_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    !ioRd |=> ioRdata == $past(ioRdata))
    else $error("read byte changed without a read strobe");

  enable_key_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ2]
    wrEn && ioWdata == 8'h0C |=> wdOn)
    else $error("enable key did not switch watchdog on");
  enable_drop_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ2]
    keyMiss |=> !wdOn ##1 !runQ)
    else $error("wrong enable value left the timer running");

  unit_select_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ3]
    wrUnit |=> {tk.unitSec, 7'h00} == ($past(ioWdata) & 8'h80))
    else $error("unit select not taken from bit 7");

  count_load_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ4]
    wrCountNz |=> cntQ == $past(ioWdata) && !runQ)
    else $error("time-out count not loaded");
  count_store_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ4]
    wrCnt |=> countQ == $past(ioWdata))
    else $error("time-out count not stored for read back");
  count_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ4]
    !wrCnt |=> countQ == $past(countQ))
    else $error("stored time-out count changed without a write");

  zero_disable_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
    wrCnt && ioWdata == 8'h00 ##1 !wrCnt [*3] |-> !runQ && !tk.tick)
    else $error("zero count did not disable the watchdog");
  zero_stop_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
    cntQ == 8'h00 |=> !runQ)
    else $error("timer ran with a zero count");

  status_read_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
    ioRd && hit(ioAddr, iwd_pkg::OFS_STATUS) |=> ioRdata == {7'h00, $past(statusQ)})
    else $error("status bit read back wrong");
  status_write_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
    wrSt && !expire |=> {7'h00, statusQ} == ($past(ioWdata) & 8'h01))
    else $error("status bit write not stored");
  status_sticky_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
    statusQ && !wrSt |=> statusQ)
    else $error("time-out status dropped without a clear");
  status_stop_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
    statusQ |=> !runQ)
    else $error("timer kept running after a time-out");

  expiry_sets_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    lastTick |=> statusQ && timeoutOut && cntQ == 8'h00 && !runQ)
    else $error("expiry did not raise time-out");
  status_rise_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    !statusQ && !wrSt && !expire |=> !statusQ)
    else $error("time-out status set without expiry");
  count_down_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    liveTick ##0 cntQ > 8'h01 |=> cntQ == $past(cntQ) - 8'h01)
    else $error("timer did not step down by one unit");
  count_steady_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    !tk.tick && !wrCnt |=> cntQ == $past(cntQ))
    else $error("live count moved between unit ticks");
  start_run_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    !runQ && !wrCnt && !stopReq |=> runQ)
    else $error("armed timer did not start");
endmodule : iwd_watchdog

// [design/iwd_pkg.sv]
// iwd_pkg: constants of the io-mapped watchdog
// assumes: byte-wide io port cycles timed by core_clk at 200 MHz
package iwd_pkg;
  localparam logic [15:0] IO_BASE = 16'h0A00;
  localparam logic [7:0] OFS_ENABLE = 8'h47;
  localparam logic [7:0] OFS_UNIT = 8'h65;
  localparam logic [7:0] OFS_COUNT = 8'h66;
  localparam logic [7:0] OFS_STATUS = 8'h67;
  localparam logic [7:0] ENABLE_KEY = 8'h0C;
  localparam int UNIT_SEC_BIT = 7;
  localparam int STATUS_BIT = 0;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] UNIT_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam longint CLK_PERIOD_NS = 5;
  localparam longint SECOND_NS = 1_000_000_000;
  localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int MINUTE_SECONDS = 60;
endpackage : iwd_pkg

// [design/iwd_tick_if.sv]
// iwd_tick_if: unit tick handshake between watchdog core and prescaler
// assumes: both ends on core_clk
`timescale 1ns/1ps
interface iwd_tick_if;
  logic run;     // prescaler counts while high
  logic unitSec; // 1 = seconds, 0 = minutes
  logic tick;    // one-cycle pulse per elapsed unit
  modport core (output run, output unitSec, input tick);
  modport scaler (input run, input unitSec, output tick);
endinterface : iwd_tick_if

// [design/iwd_prescaler.sv]
// iwd_prescaler: divides core_clk down to second or minute ticks
// assumes: run drops whenever the timer is stopped or reloaded
`timescale 1ns/1ps
module iwd_prescaler #(
  parameter int SEC_CYCLES = iwd_pkg::SEC_CYCLES,
  parameter int MIN_SECS = iwd_pkg::MINUTE_SECONDS
) (
  input wire logic core_clk, // system clock
  input wire logic rst,      // async reset, high
  iwd_tick_if.scaler tk      // tick request and pulse
);
  initial begin
    // the seconds-of-minute counter is only eight bits wide
    if (SEC_CYCLES < 1 || MIN_SECS < 1 || MIN_SECS > 256) $error("iwd_prescaler: bad divider");
  end

  logic [31:0] cycQ, cycD;
  logic [7:0] secQ, secD;
  logic tickQ, tickD;
  logic secEnd;

  always_comb begin
    secEnd = (cycQ == 32'(SEC_CYCLES - 1));
    cycD = cycQ + 32'h0000_0001;
    secD = secQ;
    tickD = 1'b0;
    if (!tk.run) begin
      cycD = 32'h0000_0000;
      secD = 8'h00;
    end else if (secEnd) begin
      cycD = 32'h0000_0000;
      // minutes built from seconds so one divider serves both units
      if (tk.unitSec || secQ == 8'(MIN_SECS - 1)) begin
        secD = 8'h00;
        tickD = 1'b1;
      end else begin
        secD = secQ + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cycQ <= 32'h0000_0000;
      secQ <= 8'h00;
      tickQ <= 1'b0;
    end else begin
      cycQ <= cycD;
      secQ <= secD;
      tickQ <= tickD;
    end
  end

  assign tk.tick = tickQ & tk.run;
endmodule : iwd_prescaler

// [verif/tb_io_mapped_watchdog_timer.sv]
// tb_io_mapped_watchdog_timer: self-checking bench for the io-mapped watchdog
// assumes: SEC_CYCLES shrunk to 10, so a minute lasts 600 core_clk cycles
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_io_mapped_watchdog_timer;
  localparam int SC = 10;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ioAddr = 16'h0000;
  logic ioWr = 1'b0;
  logic ioRd = 1'b0;
  logic [7:0] ioWdata = 8'h00;
  logic [7:0] ioRdata;
  logic timeoutOut;
  logic [15:0] regs [5] = '{16'h0A47, 16'h0A65, 16'h0A66, 16'h0A67, 16'h0A68};
  int errCount = 0;
  int totalChecks = 0;
  int cyc = 0;
  int mEn = 0;
  int mUnit = 0;
  int mCnt = 0;
  int mSt = 0;
  iwd_watchdog #(.SEC_CYCLES(SC)) i_dut (
    .core_clk(core_clk), .rst(rst), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .timeoutOut(timeoutOut));
  always #2.5 core_clk = ~core_clk;
  // whole run is about 800 cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      wrapUp();
    end
  end
  function automatic logic [7:0] expv(logic [15:0] a);
    case (a)
      16'h0A47: return 8'(mEn);
      16'h0A65: return 8'(mUnit * 128);
      16'h0A66: return 8'(mCnt);
      16'h0A67: return 8'(mSt);
      default: return 8'h00;
    endcase
  endfunction : expv
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge core_clk);
    ioAddr = a;
    ioWdata = d;
    ioWr = 1'b1;
    @(negedge core_clk);
    ioWr = 1'b0;
    case (a)
      16'h0A47: mEn = d;
      16'h0A65: mUnit = d[7];
      16'h0A66: mCnt = d;
      16'h0A67: mSt = d[0];
      default: ;
    endcase
  endtask : wr
  task automatic rd(logic [15:0] a);
    @(negedge core_clk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge core_clk);
    ioRd = 1'b0;
    `CHK($sformatf("read %h", a), expv(a), ioRdata)
  endtask : rd
  task automatic idle(int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  task automatic waitHi(int lim);
    for (int i = 0; i < lim && timeoutOut !== 1'b1; i++) @(negedge core_clk);
  endtask : waitHi
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrapUp
  initial begin
    void'($urandom(11366));
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    foreach (regs[i]) rd(regs[i]);
    // writes off the io base must not land
    wr(16'h0B66, 8'h55);
    wr(16'h0066, 8'h77);
    rd(16'h0A66);
    wr(16'h0A65, 8'($urandom) | 8'h80);
    rd(16'h0A65);
    wr(16'h0A66, 8'hFF);
    rd(16'h0A66);
    $display("test registers done");
    wr(16'h0A47, 8'h0C);
    wr(16'h0A66, 8'h02);
    idle(2 * SC - 4);
    `CHK("early", 1'b0, timeoutOut)
    waitHi(10);
    mSt = 1;
    `CHK("expiry", 1'b1, timeoutOut)
    rd(16'h0A67);
    wr(16'h0A67, 8'h00);
    idle(2);
    `CHK("cleared", 1'b0, timeoutOut)
    rd(16'h0A67);
    $display("test seconds done");
    wr(16'h0A65, 8'h00);
    wr(16'h0A66, 8'h01);
    idle(60 * SC - 10);
    `CHK("minute early", 1'b0, timeoutOut)
    waitHi(20);
    mSt = 1;
    `CHK("minute expiry", 1'b1, timeoutOut)
    wr(16'h0A67, 8'h00);
    $display("test minutes done");
    wr(16'h0A65, 8'h80);
    wr(16'h0A66, 8'h03);
    idle(SC);
    wr(16'h0A66, 8'h00);
    idle(4 * SC);
    `CHK("zero count", 1'b0, timeoutOut)
    // any key but the enable value must leave the timer stopped
    wr(16'h0A47, 8'h0C ^ 8'(1 + $urandom_range(254)));
    wr(16'h0A66, 8'h01);
    idle(4 * SC);
    `CHK("bad key", 1'b0, timeoutOut)
    rd(16'h0A47);
    wr(16'h0A67, 8'h01);
    rd(16'h0A67);
    `CHK("status set", 1'b1, timeoutOut)
    $display("test disable done");
    wrapUp();
  end
endmodule : tb_io_mapped_watchdog_timer
